// ==== core/stack_pointer_limit_check.sv ====
// stack pointer update, return address forming and stack error detection
//
// Summary of operation
// - pointer holds first free word; stack grows toward higher addresses
// - push writes then increments; pop decrements then reads
// - call push zero-extends program counter msb, top bit clear
// - exception push places status low byte beside program counter msb
// - stack limit register has no reset value
// - limit bit zero always reads zero
// - every stack pointer based address is compared with the limit
// - push at limit passes; next push traps
// - stack pointer address below floor raises stack error
`timescale 1ns/1ps
module stack_pointer_limit_check
  import stack_check_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire stack_req_s req_i,
  input wire logic limit_wr_i,
  input wire logic [15:0] limit_wdata_i,
  input wire logic sp_wr_i,
  input wire logic [15:0] sp_wdata_i,
  output stack_mem_s mem_o,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] stack_limit_o,
  output logic stack_err_o
);
  // ----------------------------------------------------------------
  // limit storage
  // ----------------------------------------------------------------
  // no reset on the limit: trap results read unknown until software loads it
  logic [15:0] limit;

  stack_limit_store u_limit (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .wr_i(limit_wr_i),
    .wdata_i(limit_wdata_i),
    .limit_o(limit)
  );

  // ----------------------------------------------------------------
  // pointer and address forming
  // ----------------------------------------------------------------
  logic [15:0] stack_pointer_reg_q;
  logic [15:0] stack_pointer_reg_d;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic is_push;
  logic is_pop;
  logic uses_sp;

  function automatic logic [15:0] align_word(input logic [15:0] v);
    return {v[15:1], 1'b0};
  endfunction : align_word

  always_comb begin
    is_push = (req_i.op == OP_PUSH) || (req_i.op == OP_CALL) || (req_i.op == OP_EXC);
    is_pop = (req_i.op == OP_POP);
    uses_sp = is_push || is_pop || (req_i.op == OP_EA);
    stack_pointer_reg_d = stack_pointer_reg_q;
    addr = stack_pointer_reg_q;
    wdata = req_i.pc_low;
    case (req_i.op)
      OP_PUSH, OP_CALL, OP_EXC: begin
        addr = stack_pointer_reg_q;
        stack_pointer_reg_d = stack_pointer_reg_q + WORD_STEP;
      end
      OP_POP: begin
        stack_pointer_reg_d = stack_pointer_reg_q - WORD_STEP;
        addr = stack_pointer_reg_d;
      end
      OP_EA: begin
        addr = req_i.ea;
      end
      default: begin
        addr = stack_pointer_reg_q;
      end
    endcase
    // the msb word is the second of the pc pair; callers issue it as call/exc
    if (req_i.op == OP_CALL) begin
      wdata = {8'h00, 1'b0, req_i.pc_msb[PC_MSB_TOP-1:0]};
    end else if (req_i.op == OP_EXC) begin
      wdata = {req_i.status_low_byte, req_i.pc_msb};
    end
    if (sp_wr_i) begin
      stack_pointer_reg_d = align_word(sp_wdata_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stack_pointer_reg_q <= SP_RESET;
    end else if (ce_i) begin
      stack_pointer_reg_q <= stack_pointer_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // error detection
  // ----------------------------------------------------------------
  logic over_err;
  logic under_err;
  logic err;

  // a push at the limit is legal; addresses past it or below the floor trap
  always_comb begin
    over_err = uses_sp && (addr > limit);
    under_err = uses_sp && (addr < STACK_FLOOR);
    err = ce_i && (over_err || under_err);
  end

  // combinational so the trap lands in the offending cycle
  assign stack_err_o = err;

  // ----------------------------------------------------------------
  // registered memory request
  // ----------------------------------------------------------------
  stack_mem_s mem_q;
  stack_mem_s mem_d;

  always_comb begin
    mem_d.mem_wr = ce_i && is_push;
    mem_d.mem_rd = ce_i && is_pop;
    mem_d.addr = addr;
    mem_d.wdata = wdata;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_q <= '0;
    end else if (ce_i) begin
      // a stalled request stays on the bus; the far side shares the enable
      mem_q <= mem_d;
    end
  end

  assign mem_o = mem_q;
  assign stack_pointer_o = stack_pointer_reg_q;
  assign stack_limit_o = limit;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  push_advance_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_push && !sp_wr_i |=> stack_pointer_o == $past(stack_pointer_o) + WORD_STEP)
    else $error("push did not advance pointer by one word");
  pop_address_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_pop |=> mem_o.mem_rd && mem_o.addr == $past(stack_pointer_o) - WORD_STEP)
    else $error("pop read not at decremented pointer");
  push_address_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_push |=> mem_o.mem_wr && mem_o.addr == $past(stack_pointer_o))
    else $error("push write not at current pointer");
  call_msb_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_CALL |=> mem_o.wdata[15:7] == 9'h000)
    else $error("call push msb not zero extended");
  exc_status_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_EXC |=> mem_o.wdata[15:8] == $past(req_i.status_low_byte))
    else $error("exception push missing status byte");
  limit_align_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stack_limit_o[0] == 1'b0)
    else $error("limit bit zero not clear");
  limit_compare_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_EA && req_i.ea > stack_limit_o |-> stack_err_o)
    else $error("stack address past limit not trapped");
  push_at_limit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_PUSH && stack_pointer_o == stack_limit_o
      && stack_pointer_o >= STACK_FLOOR |-> !stack_err_o)
    else $error("push at limit trapped");
  floor_trap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_pop && stack_pointer_o - WORD_STEP < STACK_FLOOR |-> stack_err_o)
    else $error("underflow not trapped");
  err_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stack_err_o |-> ce_i && uses_sp)
    else $error("trap without stack address");


  // ----------------------------------------------------------------
  // pointer, limit and memory side
  // ----------------------------------------------------------------
  ptr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ce_i || (!is_push && !is_pop && !sp_wr_i)) |=> stack_pointer_o == $past(stack_pointer_o))
    else $error("pointer moved without push, pop or load");
  pop_retreat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_pop && !sp_wr_i |=> stack_pointer_o == $past(stack_pointer_o) - WORD_STEP)
    else $error("pop did not retreat pointer by one word");
  sp_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && sp_wr_i |=> stack_pointer_o == {$past(sp_wdata_i[15:1]), 1'b0})
    else $error("pointer load lost or not word aligned");
  limit_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && limit_wr_i |=> stack_limit_o == {$past(limit_wdata_i[15:1]), 1'b0})
    else $error("limit load lost or not word aligned");
  ea_access_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_EA
      |=> !mem_o.mem_wr && !mem_o.mem_rd && mem_o.addr == $past(req_i.ea))
    else $error("stack address access strobed memory");
  call_pc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_CALL
      |=> mem_o.wdata[PC_MSB_TOP-1:0] == $past(req_i.pc_msb[PC_MSB_TOP-1:0]))
    else $error("call push lost program counter bits");
  exc_pc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_EXC |=> mem_o.wdata[7:0] == $past(req_i.pc_msb))
    else $error("exception push lost program counter msb");

  // ----------------------------------------------------------------
  // trap conditions
  // ----------------------------------------------------------------
  pop_over_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_pop && stack_pointer_o - WORD_STEP > stack_limit_o |-> stack_err_o)
    else $error("pop past limit not trapped");
  push_over_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_push && stack_pointer_o > stack_limit_o |-> stack_err_o)
    else $error("push past limit not trapped");
  push_floor_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_push && stack_pointer_o < STACK_FLOOR |-> stack_err_o)
    else $error("push below floor not trapped");
  ea_floor_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_EA && req_i.ea < STACK_FLOOR |-> stack_err_o)
    else $error("stack address below floor not trapped");
  ea_in_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && req_i.op == OP_EA && req_i.ea >= STACK_FLOOR && req_i.ea <= stack_limit_o
      |-> !stack_err_o)
    else $error("stack address in range trapped");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  push_cov: cover property (@(posedge clk_i) disable iff (!rst_n_i) ce_i && is_push);
  at_limit_cov: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_push && stack_pointer_o == stack_limit_o);
  pop_cov: cover property (@(posedge clk_i) disable iff (!rst_n_i) ce_i && is_pop);
  over_cov: cover property (@(posedge clk_i) disable iff (!rst_n_i) over_err && ce_i);
  under_cov: cover property (@(posedge clk_i) disable iff (!rst_n_i) under_err && ce_i);
endmodule : stack_pointer_limit_check

// ==== core/stack_check_pkg.sv ====
// package: stack pointer, limit and stack error constants and carriers
package stack_check_pkg;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam int unsigned ALIGN_BIT = 0;
  localparam int unsigned PC_MSB_TOP = 7;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_PUSH,
    OP_POP,
    OP_CALL,
    OP_EXC,
    OP_EA
  } stack_op_e;

  // request from the address generation unit
  typedef struct packed {
    stack_op_e op;
    logic [15:0] pc_low;
    logic [7:0] pc_msb;
    logic [7:0] status_low_byte;
    logic [15:0] ea;
  } stack_req_s;

  // result toward memory and the exception logic
  typedef struct packed {
    logic mem_wr;
    logic mem_rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } stack_mem_s;
endpackage : stack_check_pkg

// ==== core/stack_limit_store.sv ====
// stack limit register with forced zero alignment bit and no reset value
`timescale 1ns/1ps
module stack_limit_store
  import stack_check_pkg::*;
(
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] limit_o
);
  logic [15:0] limit_q;
  logic [15:0] limit_d;

  always_comb begin
    limit_d = limit_q;
    if (wr_i) begin
      limit_d = wdata_i;
    end
    limit_d[ALIGN_BIT] = 1'b0;
  end

  // no reset on purpose: contents unknown until software loads them
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      limit_q <= limit_d;
    end
  end

  assign limit_o = {limit_q[15:1], 1'b0};
endmodule : stack_limit_store

// ==== sim/stack_mem_model.sv ====
// far side model: exception logic that counts stack error traps
`timescale 1ns/1ps
module stack_mem_model
  import stack_check_pkg::*;
(
  input wire logic clk_i,
  input wire logic ce_i,
  input wire stack_mem_s mem_i,
  input wire logic err_i,
  output int traps_o,
  output int accesses_o
);
  initial traps_o = 0;
  initial accesses_o = 0;
  // one trap per offending cycle, taken at the edge that ends it
  // a request is consumed at the first enabled edge; a stalled one stays on the bus
  always @(posedge clk_i) begin
    if (err_i) traps_o++;
    if (ce_i && (mem_i.mem_wr || mem_i.mem_rd)) accesses_o++;
  end
endmodule : stack_mem_model

// ==== sim/test_stack_pointer_limit_check.sv ====
// self-checking bench for the stack pointer limit check
`timescale 1ns/1ps
module test_stack_pointer_limit_check;
  import stack_check_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ce_i = 1, limit_wr_i = 0, sp_wr_i = 0, stack_err_o;
  logic [15:0] limit_wdata_i = 16'h0000, sp_wdata_i = 16'h0000, rnd = 16'h005f;
  logic [15:0] sp = 16'h0800, lim, stack_pointer_o, stack_limit_o;
  stack_req_s req_i = '0;
  stack_mem_s mem_o;
  int fails = 0, comparisons = 0, traps, exp_traps = 0, accesses, exp_acc = 0;
  int stack_q[$];  // addresses of live pushes, newest last
  logic [1:0] m_strobe = 2'h0;
  logic [15:0] m_addr = 16'h0000, m_data = 16'h0000;  // request the far side should see

  initial forever #2 clk_i = ~clk_i;

  stack_pointer_limit_check DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .req_i(req_i), .limit_wr_i(limit_wr_i), .limit_wdata_i(limit_wdata_i),
    .sp_wr_i(sp_wr_i), .sp_wdata_i(sp_wdata_i), .mem_o(mem_o),
    .stack_pointer_o(stack_pointer_o), .stack_limit_o(stack_limit_o),
    .stack_err_o(stack_err_o));
  stack_mem_model far_end (.clk_i(clk_i), .ce_i(ce_i), .mem_i(mem_o), .err_i(stack_err_o),
    .traps_o(traps), .accesses_o(accesses));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic void next_rnd();
    rnd ^= rnd << 7;
    rnd ^= rnd >> 9;
    rnd ^= rnd << 8;
  endfunction : next_rnd

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp16

  task automatic conclude();
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick

  // lw high loads the limit, low loads the pointer; bit zero is dropped
  task automatic load(input logic lw, input logic [15:0] v);
    req_i.op = OP_NONE;
    ce_i = 1;
    limit_wr_i = lw;
    sp_wr_i = !lw;
    limit_wdata_i = v;
    sp_wdata_i = v;
    m_strobe = 2'h0;
    m_addr = sp;
    m_data = req_i.pc_low;
    tick();
    limit_wr_i = 0;
    sp_wr_i = 0;
    if (lw) lim = v & 16'hfffe;
    else begin
      sp = v & 16'hfffe;
      stack_q.delete();
    end
    cmp16(stack_limit_o, lim, "limit");
    cmp16(stack_pointer_o, sp, "loaded pointer");
  endtask : load

  task automatic do_op(input stack_op_e op, input logic [15:0] ea);
    logic [15:0] a, w;
    logic bad, wr, rd;
    next_rnd();
    req_i.op = op;
    req_i.pc_low = rnd;
    next_rnd();
    req_i.pc_msb = rnd[15:8];
    req_i.status_low_byte = rnd[7:0];
    req_i.ea = ea;
    a = (op == OP_POP) ? sp - 16'h0002 : (op == OP_EA) ? ea : sp;
    case (op)
      OP_CALL: w = {8'h00, 1'b0, req_i.pc_msb[6:0]};
      OP_EXC: w = {req_i.status_low_byte, req_i.pc_msb};
      default: w = req_i.pc_low;
    endcase
    bad = ce_i && (a > lim || a < STACK_FLOOR);
    wr = op == OP_PUSH || op == OP_CALL || op == OP_EXC;
    rd = op == OP_POP;
    #1;
    cmp16(16'(stack_err_o), 16'(bad), "trap");
    exp_traps += bad;
    tick();
    if (ce_i) begin
      if (wr) sp = sp + 16'h0002;
      if (rd) sp = sp - 16'h0002;
      m_strobe = {wr, rd};
      m_addr = a;
      m_data = w;
      exp_acc += wr || rd;
    end
    cmp16(stack_pointer_o, sp, "pointer");
    cmp16(16'({mem_o.mem_wr, mem_o.mem_rd}), 16'(m_strobe), "strobes");
    cmp16(mem_o.addr, m_addr, "address");
    cmp16(mem_o.wdata, m_data, "pushed word");
    if (ce_i && rd && stack_q.size() > 0) begin
      cmp16(mem_o.addr, 16'(stack_q.pop_back()), "lifo slot");
    end
    if (ce_i && wr) stack_q.push_back(int'(a));
  endtask : do_op

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1;
    cmp16(stack_pointer_o, SP_RESET, "reset pointer");
    cmp16(stack_limit_o, 16'hxxxx & 16'hfffe, "reset limit");
    load(1, 16'h0811);  // odd limit value
    repeat (10) do_op(OP_PUSH, 16'h0000);  // equal passes, next traps
    repeat (11) do_op(OP_POP, 16'h0000);  // ends below the floor
    load(0, 16'h0901);
    do_op(OP_EA, 16'h0900);
    load(1, 16'h0a01);
    do_op(OP_PUSH, 16'h0000);  // no pointer load right after a limit write
    // random mix of every op but OP_NONE, stalls and addresses around floor and limit
    repeat (80) begin
      next_rnd();
      ce_i = rnd[3:0] != 4'h0;
      do_op(stack_op_e'(3'(rnd[15:13] % 3'd5 + 3'd1)), {4'h0, rnd[11:1], 1'b0});
    end
    req_i.op = OP_NONE;
    ce_i = 1;  // lets the far side take a request still held by a stall
    tick();
    cmp16(16'(traps), 16'(exp_traps), "trap count");
    cmp16(16'(accesses), 16'(exp_acc), "memory accesses");
    conclude();
  end
endmodule : test_stack_pointer_limit_check
